/* logic/key_wakeup_control.sv */
/*
 key-on wakeup control: write-only enables, halt entry, halt release,
 sticky events with mask and interrupt, Avalon-MM slave.
 assumes synchronous pins, one 10 MHz clock, synchronous high reset.
*/
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "key_wake_map.svh"
// Overview of operation
// - four enable bits in bits seven..four
// - halt by control write, leave on key
// - pending release at entry skips the halt
// - release pin always a release source
module key_wakeup_control
	import key_wake_pkg::*;
#(
	parameter int KEYS = 4,
	parameter int WARMUP = `KW_WARMUP_CYCLES
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset,
	// avalon-mm slave
	input wire logic [9:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// pins
	input wire logic [KEYS-1:0] i_keys,
	input wire logic i_release_pin,
	// status outputs
	output logic o_halted,
	output logic o_warmup,
	output logic o_release_mode,
	output logic o_irq
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [KEYS-1:0] enable_reg; // key release enables
	logic mode_reg; // release mode select, 1 = level
	logic [2:0] status_reg; // sticky events
	logic [2:0] mask_reg; // interrupt mask
	logic [2:0] events; // this cycle's events
	logic [15:0] warm_reg; // warmup countdown
	power_state_t state_reg; // sequencer state
	logic key_request; // gated key request
	logic any_request; // key or release pin
	logic access_reg; // one wait state done
	logic take; // access completes this cycle
	logic halt_cmd; // software halt command
	logic [31:0] read_next; // read mux
	wake_events_t ev; // named view of events
	// detector, valid with clock stopped
	// gated key request
	key_wake_detect #(.KEYS(KEYS)) u_detect (
		.i_keys(i_keys),
		.i_enable(enable_reg),
		.i_release_pin(i_release_pin),
		.o_key_request(key_request),
		.o_any_request(any_request)
	);
	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------
	// one wait state per access keeps read data registered
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			access_reg <= 1'b0;
		end else begin
			access_reg <= (i_read | i_write) & ~access_reg;
		end
	end
	assign take = access_reg & (i_read | i_write);
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_waitrequest <= 1'b1;
		end else begin
			o_waitrequest <= ~((i_read | i_write) & ~access_reg);
		end
	end
	assign halt_cmd = take & i_write & (i_address == `KW_ADDR_CONTROL) & i_writedata[`KW_CTL_HALT];
	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// enables from bits seven..four
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			enable_reg <= KEYS'(`KW_EN_RESET);
		end else if (take && i_write && i_address == `KW_ADDR_ENABLE) begin
			enable_reg <= i_writedata[`KW_EN_MSB:`KW_EN_LSB];
		end
	end
	// release mode and mask
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			mode_reg <= 1'b0;
			mask_reg <= `KW_IRQ_RESET;
		end else if (take && i_write) begin
			if (i_address == `KW_ADDR_CONTROL) begin
				mode_reg <= i_writedata[`KW_CTL_RELEASE_MODE_SELECT];
			end
			if (i_address == `KW_ADDR_MASK) begin
				mask_reg <= i_writedata[2:0];
			end
		end
	end
	// ----------------------------------------------------------------
	// halt sequencer
	// ----------------------------------------------------------------
	// level mode uses the level, edge mode the same gated request;
	// mode_reg gates nothing here, so keys and the pin release in both modes
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			state_reg <= st_run;
			warm_reg <= 16'h0000;
		end else begin
			unique case (state_reg)
				st_run: begin
					if (halt_cmd) begin
						if (any_request) begin
							state_reg <= st_warmup;
						end else begin
							state_reg <= st_halt;
						end
						warm_reg <= 16'(WARMUP);
					end
				end
				st_halt: begin
					if (any_request) begin
						state_reg <= st_warmup;
					end
				end
				st_warmup: begin
					// warmup countdown before running again
					if (warm_reg <= 16'h0001) begin
						state_reg <= st_run;
					end else begin
						warm_reg <= warm_reg - 16'h0001;
					end
				end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// events and interrupt
	// ----------------------------------------------------------------
	assign ev.woke = (state_reg == st_halt) & any_request;
	assign ev.refused = (state_reg == st_run) & halt_cmd & any_request;
	assign ev.halted = (state_reg == st_run) & halt_cmd & ~any_request;
	assign events = ev;
	// sticky flags, set wins over a write-one clear
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			status_reg <= `KW_IRQ_RESET;
		end else if (take && i_write && i_address == `KW_ADDR_STATUS) begin
			status_reg <= (status_reg & ~i_writedata[2:0]) | events;
		end else begin
			status_reg <= status_reg | events;
		end
	end
	// outputs from flip-flops
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_irq <= 1'b0;
			o_halted <= 1'b0;
			o_warmup <= 1'b0;
			o_release_mode <= 1'b0;
		end else begin
			o_irq <= |((status_reg | events) & mask_reg);
			o_halted <= (state_reg == st_halt) & ~any_request;
			o_warmup <= state_reg == st_warmup;
			o_release_mode <= mode_reg;
		end
	end
	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// enables never read back; unmapped reads return zero
	always_comb begin
		read_next = 32'h00000000;
		unique case (i_address)
			`KW_ADDR_CONTROL: read_next = {30'h00000000, mode_reg, 1'b0};
			`KW_ADDR_STATUS: read_next = {29'h00000000, status_reg};
			`KW_ADDR_MASK: read_next = {29'h00000000, mask_reg};
			`KW_ADDR_LEVELS: read_next = {26'h0000000, key_request, i_release_pin, i_keys};
			default: read_next = 32'h00000000;
		endcase
	end
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_readdata <= 32'h00000000;
		end else if (i_read && !access_reg) begin
			o_readdata <= read_next;
		end
	end
endmodule // key_wakeup_control
`default_nettype wire

/* inc/key_wake_map.svh */
/*
 key wakeup register map, field positions, reset values and timing counts.
 assumes inclusion by bare name from the package and the design files.
*/
`ifndef KEY_WAKE_MAP_SVH
`define KEY_WAKE_MAP_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses; printed index times four)
// ----------------------------------------------------------------
`define KW_IDX_ENABLE 8'h31
`define KW_ADDR_ENABLE 10'h0c4
`define KW_ADDR_CONTROL 10'h100
`define KW_ADDR_STATUS 10'h104
`define KW_ADDR_MASK 10'h108
`define KW_ADDR_LEVELS 10'h10c
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define KW_EN_LSB 4
`define KW_EN_MSB 7
`define KW_CTL_HALT 0
`define KW_CTL_RELEASE_MODE_SELECT 1
`define KW_ST_WAKE 0
`define KW_ST_REFUSE 1
`define KW_ST_HALT 2
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define KW_EN_RESET 4'h0
`define KW_IRQ_RESET 3'h0
`define KW_WARMUP_NS 1600
`define KW_CLOCK_NS 100
`define KW_WARMUP_CYCLES ((`KW_WARMUP_NS + `KW_CLOCK_NS - 1) / `KW_CLOCK_NS)
`endif

/* inc/key_wake_pkg.sv */
/*
 types shared by the key wakeup design files.
 assumes the map header is on the include path.
*/
package key_wake_pkg;
	`include "key_wake_map.svh"
	// power state of the halt sequencer
	typedef enum logic [1:0] {st_run, st_halt, st_warmup} power_state_t;
	// sticky event flags
	typedef struct packed {
		logic halted;
		logic refused;
		logic woke;
	} wake_events_t;
	// pin group
	typedef struct packed {
		logic release_pin;
		logic [3:0] keys;
	} wake_pins_t;
endpackage

/* logic/key_wake_detect.sv */
/*
 combinational wakeup request from the key inputs and release pin.
 assumes pin levels already synchronous; works without a clock.
*/
`timescale 1ns/1ps
`default_nettype none
module key_wake_detect
	import key_wake_pkg::*;
#(
	parameter int KEYS = 4
) (
	// pins and enables
	input wire logic [KEYS-1:0] i_keys,
	input wire logic [KEYS-1:0] i_enable,
	input wire logic i_release_pin,
	// requests
	output logic o_key_request,
	output logic o_any_request
);
	// ----------------------------------------------------------------
	// detection
	// ----------------------------------------------------------------
	// gated low-level OR
	assign o_key_request = |(~i_keys & i_enable);
	assign o_any_request = o_key_request | i_release_pin;
endmodule // key_wake_detect
`default_nettype wire

/* testbench/key_wake_assertions.sv */
/*
 port checker for key_wakeup_control, bound into each instance.
 assumes one clock with synchronous high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module key_wake_checker #(
	parameter int KEYS = 4,
	parameter int WARMUP = 16
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset,
	// bus
	input wire logic [9:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [31:0] o_readdata,
	input wire logic o_waitrequest,
	// pins and status
	input wire logic [KEYS-1:0] i_keys,
	input wire logic i_release_pin,
	input wire logic o_halted,
	input wire logic o_warmup,
	input wire logic o_release_mode,
	input wire logic o_irq
);
	// ----
	// helpers
	// ----
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);
	// halt command taken at this edge
	wire logic halt_cmd = i_write && !o_waitrequest && i_address == 10'h100 && i_writedata[0];
	// warmup length; counted since a repetition cannot take the parameter
	int warm_cnt;
	always_ff @(posedge i_clock) begin
		warm_cnt <= (i_reset || !o_warmup) ? 0 : warm_cnt + 1;
	end
	// ----
	// assertions
	// ----
	// quiet after reset
	chk_reset_quiet: assert property ($past(i_reset) |-> o_waitrequest && !o_halted && !o_warmup && !o_irq)
		else $error("outputs busy after reset");
	chk_enable_unread: assert property (i_read && !o_waitrequest && i_address == 10'h0c4 |-> o_readdata == 32'h0)
		else $error("enable register readable");
	chk_halt_entry: assert property (halt_cmd && !i_release_pin && &i_keys |-> ##[1:3] o_halted)
		else $error("halt not entered");
	chk_halt_hold: assert property (o_halted && !i_release_pin && &i_keys |=> o_halted)
		else $error("halt left without cause");
	chk_refuse_nohalt: assert property (halt_cmd && i_release_pin |=> !o_halted [*4])
		else $error("halted despite pending release");
	chk_refuse_warm: assert property (halt_cmd && i_release_pin |-> ##[1:3] o_warmup)
		else $error("no warmup on refused halt");
	chk_pin_release: assert property (o_halted && i_release_pin |-> ##[1:2] (o_warmup && !o_halted))
		else $error("release pin ignored");
	chk_warmup_len: assert property ($fell(o_warmup) |-> warm_cnt == WARMUP)
		else $error("warmup length wrong");
	// main scenarios
	cover property (halt_cmd && o_release_mode);
	cover property ($fell(o_halted));
	cover property ($rose(o_irq));
endmodule // key_wake_checker
bind key_wakeup_control key_wake_checker #(.KEYS(KEYS), .WARMUP(WARMUP)) u_chk (
	.i_clock(i_clock), .i_reset(i_reset), .i_address(i_address), .i_read(i_read), .i_write(i_write),
	.i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_keys(i_keys),
	.i_release_pin(i_release_pin), .o_halted(o_halted), .o_warmup(o_warmup),
	.o_release_mode(o_release_mode), .o_irq(o_irq)
);
`default_nettype wire

/* testbench/key_wake_switches.sv */
/*
 model of the key switches and release pin driver.
 assumes the bench sets which keys are pressed.
*/
`timescale 1ns/1ps
`default_nettype none
module key_wake_switches (
	// commands
	input wire logic [3:0] i_press,
	input wire logic i_pin_high,
	// pins
	output logic [3:0] o_keys,
	output logic o_release_pin
);
	// idle keys high
	// open switches sit at the pull-up level, never a wake source
	assign o_keys = ~i_press;
	assign o_release_pin = i_pin_high;
endmodule // key_wake_switches
`default_nettype wire

/* testbench/test_key_wakeup_control.sv */
/*
 self-checking bench for key_wakeup_control.
 assumes one wait state per access and a short warmup.
*/
`timescale 1ns/1ps
`default_nettype none
module test_key_wakeup_control;
	// stimulus and observed signals
	logic i_clock = 1'b0;
	logic i_reset = 1'b1;
	logic [9:0] address = 10'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic [3:0] press = 4'h0;
	logic pin_high = 1'b0;
	logic [3:0] keys;
	logic release_pin, halted, warmup, release_mode, irq;
	int n_errors = 0;
	int n_tests = 0;
	initial begin
		forever #50 i_clock = ~i_clock;
	end
	key_wakeup_control #(.KEYS(4), .WARMUP(2)) u_dut (.i_clock(i_clock), .i_reset(i_reset),
		.i_address(address), .i_read(read), .i_write(write), .i_writedata(writedata),
		.o_readdata(readdata), .o_waitrequest(waitrequest), .i_keys(keys), .i_release_pin(release_pin),
		.o_halted(halted), .o_warmup(warmup), .o_release_mode(release_mode), .o_irq(irq));
	key_wake_switches u_sw (.i_press(press), .i_pin_high(pin_high), .o_keys(keys), .o_release_pin(release_pin));
	// ----
	// shared tasks
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	// request held until waitrequest is sampled low; the watchdog bounds it
	task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge i_clock);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do @(posedge i_clock); while (waitrequest !== 1'b0);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [9:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q, e);
	endtask
	// bounded wait for halted (0) or warmup (1)
	task automatic wait_sig(input logic which, input logic v);
		for (int n = 0; n < 40 && (which ? warmup : halted) !== v; n++) @(posedge i_clock);
	endtask
	task automatic irq_is(input logic v);
		repeat (2) @(posedge i_clock);
		check({31'h0, irq}, {31'h0, v});
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_regs();
		check({31'h0, waitrequest}, 32'h1);
		rdc(10'h0c4, 32'h0);
		rdc(10'h104, 32'h0);
		rdc(10'h3fc, 32'h0);
		wr(10'h0c4, 32'hf0);
		rdc(10'h0c4, 32'h0);
	endtask
	task automatic t_gate();
		for (int k = 0; k < 4; k++) begin
			wr(10'h0c4, 32'h10 << k);
			press <= 4'h1 << k;
			rdc(10'h10c, 32'h20 | (32'hf ^ (32'h1 << k)));
			press <= 4'h1 << ((k + 1) % 4);
			rdc(10'h10c, 32'hf ^ (32'h1 << ((k + 1) % 4)));
		end
		press <= 4'h0;
	endtask
	task automatic t_wake();
		wr(10'h108, 32'h1);
		wr(10'h0c4, 32'h20);
		rdc(10'h10c, 32'hf);
		wr(10'h100, 32'h3);
		wait_sig(1'b0, 1'b1);
		check({31'h0, halted}, 32'h1);
		check({31'h0, release_mode}, 32'h1);
		press <= 4'h1;
		repeat (4) @(posedge i_clock);
		check({31'h0, halted}, 32'h1);
		press <= 4'h2;
		wait_sig(1'b1, 1'b1);
		check({31'h0, warmup}, 32'h1);
		press <= 4'h0;
		irq_is(1'b1);
		wr(10'h108, 32'h0);
		irq_is(1'b0);
		wr(10'h108, 32'h1);
		irq_is(1'b1);
		rdc(10'h104, 32'h5);
		wr(10'h104, 32'h7);
		irq_is(1'b0);
	endtask
	task automatic t_refuse();
		for (int c = 0; c < 2; c++) begin
			wr(10'h0c4, c ? 32'h80 : 32'h0);
			press <= c ? 4'h8 : 4'h0;
			pin_high <= !c;
			wr(10'h100, c ? 32'h3 : 32'h1);
			wait_sig(1'b1, 1'b1);
			check({31'h0, warmup}, 32'h1);
			rdc(10'h104, 32'h2);
			wr(10'h104, 32'h7);
		end
		press <= 4'h0;
		pin_high <= 1'b0;
	endtask
	task automatic t_pin();
		wr(10'h100, 32'h3);
		wait_sig(1'b0, 1'b1);
		pin_high <= 1'b1;
		wait_sig(1'b1, 1'b1);
		check({31'h0, warmup}, 32'h1);
		pin_high <= 1'b0;
		rdc(10'h104, 32'h5);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge i_clock);
		i_reset <= 1'b0;
		t_regs();
		t_gate();
		t_wake();
		t_refuse();
		t_pin();
		summarize();
	end
	// watchdog: far beyond the few hundred cycles needed
	initial begin
		#2000000;
		n_errors++;
		summarize();
	end
endmodule // test_key_wakeup_control
`default_nettype wire
